// >>> logic/mds_pkg.sv
/*
 Shared constants and types of the modulation data source block.
 Assumes a single 100 MHz system clock and an SPI style register port.
*/
package mds_pkg;

   // Register addresses (7-bit SPI address space)
   localparam logic [6:0] MDS_A_IE1 = 7'h05;
   localparam logic [6:0] MDS_A_IE2 = 7'h06;
   localparam logic [6:0] MDS_A_OPM = 7'h07;
   localparam logic [6:0] MDS_A_OP2 = 7'h08;
   localparam logic [6:0] MDS_A_PHC = 7'h30;
   localparam logic [6:0] MDS_A_MOD = 7'h71;
   localparam logic [6:0] MDS_A_FIFO = 7'h7f;

   // Bit positions
   localparam int unsigned MDS_B_PLLON = 1;
   localparam int unsigned MDS_B_RXON = 2;
   localparam int unsigned MDS_B_TXON = 3;
   localparam int unsigned MDS_B_MPK = 4;
   localparam int unsigned MDS_B_PHEN = 3;

   // Reset values
   localparam logic [7:0] MDS_MOD_RST = 8'h00;
   localparam logic [7:0] MDS_OPM_RST = 8'h00;
   localparam logic [7:0] MDS_REG_RST = 8'h00;
   localparam logic [8:0] MDS_PN9_SEED = 9'h1ff;

   // Sizes and counts
   localparam int unsigned MDS_FIFO_W = 8;
   localparam int unsigned MDS_FIFO_D = 4;
   localparam logic [2:0] MDS_BIT_LAST = 3'h7;

   typedef enum logic [1:0] {MDS_CW, MDS_OOK, MDS_FSK, MDS_GAUSSIAN_FSK} mds_mod_e;
   typedef enum logic [1:0] {MDS_SRC_GPIO, MDS_SRC_SDI, MDS_SRC_FIFO,
      MDS_SRC_PN9} mds_src_e;
   typedef enum logic [1:0] {MDS_CLK_NONE, MDS_CLK_GPIO, MDS_CLK_SDO,
      MDS_CLK_IRQ} mds_clk_e;
   typedef enum logic [1:0] {MDS_STANDBY, MDS_TUNE, MDS_TX,
      MDS_RX} mds_state_e;

   // Layout of the modulation mode control register, msb first
   typedef struct packed {
      mds_clk_e clk;
      mds_src_e src;
      logic inv;
      logic dev_msb;
      mds_mod_e mods;
   } mds_cfg_s;

   // One two-way pin: level driven and its active-low enable
   typedef struct packed {
      logic out;
      logic oe_n;
   } mds_pin_s;

endpackage

// >>> logic/mds_modsrc.sv
/*
 Modulation data source control: SPI register port, source selection,
 data clock routing, automatic TX/RX exit and a small byte FIFO.
 Assumes a half-bit tick from the data rate generator and a demodulator
 bit, sync and packet-valid strobes, all on sys_clk.
*/
// How it works
// - modtyp field picks carrier, keying type
// - Gaussian keying in direct needs data clock
// - source field picks gpio, sdi, FIFO, pseudorandom
// - inversion bit flips transmit data polarity
// - FIFO reached through one burst access register
// - packet handler wraps FIFO bytes in frame
// - no handler: host loads whole packet
// - receive stores only bytes after sync
// - demodulated bits shown live during FIFO receive
// - packet events exit to programmed idle state
// - packet sent clears txon, tune or standby
// - packet valid clears rxon unless multi-packet
// - direct mode bypasses FIFO, real time
// - clock routing field picks clock pin
// - plain keying needs data pin only
// - direct receive drives data, clock live
// - host programs preamble threshold for direct
// - transmit clock square wave at data rate
// - all keying types in synchronous direct
// - never store preamble or sync bytes
// - serial pins are SPI while select low
// - interrupt pin clocks only with none enabled
// - no Gaussian keying in asynchronous direct
`timescale 1ns/1ns

module mds_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned D = 4
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [W-1:0] wr_data,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [W-1:0] rd_data
);
   localparam int unsigned AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } mds_fifo_s;
   mds_fifo_s s_ff, nxt_s;
   logic push, pop;

   // Handshakes; full and empty come straight from the count
   assign wr_ready = (s_ff.cnt != (AW+1)'(D));
   assign rd_valid = (s_ff.cnt != '0);
   assign rd_data = s_ff.mem[s_ff.rp];
   assign push = wr_valid & wr_ready;
   assign pop = rd_valid & rd_ready;

   // Pointer and count update
   always_comb
   begin
      nxt_s = s_ff;
      if (push)
      begin
         nxt_s.mem[s_ff.wp] = wr_data;
         nxt_s.wp = (s_ff.wp == AW'(D - 1)) ? '0 : s_ff.wp + 1'b1;
      end
      if (pop)
         nxt_s.rp = (s_ff.rp == AW'(D - 1)) ? '0 : s_ff.rp + 1'b1;
      nxt_s.cnt = s_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         s_ff <= '0;
      else
         s_ff <= nxt_s;
   end
endmodule // mds_fifo

module mds_modsrc (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic chip_select_n,
   input wire logic spi_clk,
   input wire logic sdi_in,
   input wire logic gpio_data_in,
   input wire logic half_bit_tick,
   input wire logic rx_demod_bit,
   input wire logic rx_sync_seen,
   input wire logic pkt_valid,
   input wire logic irq_request,
   output mds_pkg::mds_pin_s sdi_pin,
   output mds_pkg::mds_pin_s sdo_pin,
   output logic gpio_clk_out,
   output logic rx_bit_output,
   output logic interrupt_out_n,
   output logic tx_mod_bit,
   output mds_pkg::mds_mod_e mod_type_out,
   output mds_pkg::mds_state_e op_state,
   output logic ph_wrap,
   output logic pkt_sent
);
   import mds_pkg::*;

   typedef struct packed {
      logic cs_m, cs_s, sck_m, sck_s, sck_d, sdi_m, sdi_s, gdi_m, gdi_s;
      logic [2:0] bcnt;
      logic first;
      logic wr;
      logic [6:0] addr;
      logic [7:0] shin;
      logic [7:0] shout;
      logic [7:0] ie1, ie2, opm, op2, phc;
      mds_cfg_s mc;
      mds_cfg_s act;
      mds_state_e st;
      logic dclk;
      logic [8:0] lfsr;
      logic [7:0] txsh;
      logic [2:0] txcnt;
      logic txgo;
      logic rxcol;
      logic [7:0] rxsh;
      logic [2:0] rxcnt;
      logic rxpend;
      logic [7:0] rxbyte;
      mds_pin_s sdo, sdi;
      logic gclk, rxbit, irqn, txbit, wrap, sent;
      mds_mod_e mo;
   } mds_top_s;

   mds_top_s s_ff, nxt_s;
   logic f_wv, f_wr, f_rv, f_rr;
   logic [7:0] f_wd, f_rd;

   // Single buffer; its owner flips with the TX/RX direction
   mds_fifo #(.W(MDS_FIFO_W), .D(MDS_FIFO_D)) u_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .wr_valid(f_wv),
      .wr_ready(f_wr),
      .wr_data(f_wd),
      .rd_valid(f_rv),
      .rd_ready(f_rr),
      .rd_data(f_rd)
   );

   // Register readback; FIFO reads return zero when empty
   function automatic logic [7:0] mds_rd(input mds_top_s s,
      input logic [6:0] a, input logic fv, input logic [7:0] fd);
      logic [7:0] r;
      r = 8'h00;
      unique case (a)
         MDS_A_IE1: r = s.ie1;
         MDS_A_IE2: r = s.ie2;
         MDS_A_OPM: r = s.opm;
         MDS_A_OP2: r = s.op2;
         MDS_A_PHC: r = s.phc;
         MDS_A_MOD: r = s.mc;
         MDS_A_FIFO: r = fv ? fd : 8'h00;
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // Next state of the whole block
   always_comb
   begin
      logic rise, fall, rd, act_on, edge_up, direct, async_m, pin;
      logic [7:0] byte_in;
      logic [6:0] ra;
      rise = s_ff.sck_s & ~s_ff.sck_d;
      fall = ~s_ff.sck_s & s_ff.sck_d;
      byte_in = {s_ff.shin[6:0], s_ff.sdi_s};
      rd = 1'b0;
      ra = s_ff.addr;
      act_on = (s_ff.st == MDS_TX) || (s_ff.st == MDS_RX);
      direct = ~s_ff.act.src[1];
      async_m = direct && (s_ff.act.clk == MDS_CLK_NONE);
      pin = (s_ff.act.src == MDS_SRC_GPIO) ? s_ff.gdi_s
         : (s_ff.sdi_s & s_ff.cs_s);
      edge_up = act_on & half_bit_tick & ~s_ff.dclk;
      nxt_s = s_ff;
      f_wv = 1'b0;
      f_wd = byte_in;
      f_rr = 1'b0;
      nxt_s.sent = 1'b0;

      // Two-stage synchronisers for every pin input
      nxt_s.cs_m = chip_select_n;
      nxt_s.cs_s = s_ff.cs_m;
      nxt_s.sck_m = spi_clk;
      nxt_s.sck_s = s_ff.sck_m;
      nxt_s.sck_d = s_ff.sck_s;
      nxt_s.sdi_m = sdi_in;
      nxt_s.sdi_s = s_ff.sdi_m;
      nxt_s.gdi_m = gpio_data_in;
      nxt_s.gdi_s = s_ff.gdi_m;

      // Operating state follows the on bits; config latched on entry
      if (s_ff.opm[MDS_B_TXON])
         nxt_s.st = MDS_TX;
      else if (s_ff.opm[MDS_B_RXON])
         nxt_s.st = MDS_RX;
      else if (s_ff.opm[MDS_B_PLLON])
         nxt_s.st = MDS_TUNE;
      else
         nxt_s.st = MDS_STANDBY;
      if (!act_on && (nxt_s.st == MDS_TX || nxt_s.st == MDS_RX))
         nxt_s.act = s_ff.mc;

      // Data clock is a square wave, one period per bit; it runs from
      // receive entry so bit timing is held through the preamble
      if (!act_on)
         nxt_s.dclk = 1'b0;
      else if (half_bit_tick)
         nxt_s.dclk = ~s_ff.dclk;

      // Transmit data path
      if (s_ff.st != MDS_TX)
      begin
         nxt_s.txcnt = 3'h0;
         nxt_s.txgo = 1'b0;
         nxt_s.lfsr = MDS_PN9_SEED;
      end
      else if (async_m)
         nxt_s.txbit = pin ^ s_ff.act.inv;
      else if (edge_up)
      begin
         unique case (s_ff.act.src)
            MDS_SRC_GPIO, MDS_SRC_SDI:
               nxt_s.txbit = pin ^ s_ff.act.inv;
            MDS_SRC_PN9:
            begin
               nxt_s.txbit = s_ff.lfsr[8] ^ s_ff.act.inv;
               nxt_s.lfsr = {s_ff.lfsr[7:0],
                  s_ff.lfsr[8] ^ s_ff.lfsr[4]};
            end
            MDS_SRC_FIFO:
            begin
               if (s_ff.txcnt != 3'h0)
               begin
                  nxt_s.txbit = s_ff.txsh[7] ^ s_ff.act.inv;
                  nxt_s.txsh = {s_ff.txsh[6:0], 1'b0};
                  nxt_s.txcnt = s_ff.txcnt - 3'h1;
               end
               else if (f_rv)
               begin
                  f_rr = 1'b1;
                  nxt_s.txbit = f_rd[7] ^ s_ff.act.inv;
                  nxt_s.txsh = {f_rd[6:0], 1'b0};
                  nxt_s.txcnt = MDS_BIT_LAST;
                  nxt_s.txgo = 1'b1;
               end
               else if (s_ff.txgo)
               begin
                  // FIFO drained: drop back to the idle bits
                  nxt_s.sent = 1'b1;
                  nxt_s.txgo = 1'b0;
                  nxt_s.opm[MDS_B_TXON] = 1'b0;
               end
            end
         endcase
      end
      // Frame fields are added only with the handler on
      nxt_s.wrap = (s_ff.st == MDS_TX) && (s_ff.act.src == MDS_SRC_FIFO)
         && s_ff.phc[MDS_B_PHEN];

      // Receive data path; bytes only after sync, never the preamble
      nxt_s.rxbit = (s_ff.st == MDS_RX) & rx_demod_bit;
      if (s_ff.st != MDS_RX || s_ff.act.src != MDS_SRC_FIFO)
      begin
         nxt_s.rxcol = 1'b0;
         nxt_s.rxcnt = 3'h0;
      end
      else
      begin
         if (rx_sync_seen)
            nxt_s.rxcol = 1'b1;
         f_wv = s_ff.rxpend;
         f_wd = s_ff.rxbyte;
         if (f_wr)
            nxt_s.rxpend = 1'b0;
         if (edge_up && s_ff.rxcol)
         begin
            nxt_s.rxsh = {s_ff.rxsh[6:0], rx_demod_bit};
            nxt_s.rxcnt = s_ff.rxcnt + 3'h1;
            if (s_ff.rxcnt == MDS_BIT_LAST)
            begin
               nxt_s.rxpend = 1'b1; // a full buffer overwrites here
               nxt_s.rxbyte = {s_ff.rxsh[6:0], rx_demod_bit};
            end
         end
         if (pkt_valid)
         begin
            nxt_s.rxcol = 1'b0;
            nxt_s.rxcnt = 3'h0;
            if (!s_ff.op2[MDS_B_MPK])
               nxt_s.opm[MDS_B_RXON] = 1'b0;
         end
      end

      // SPI slave: address byte, then burst data bytes
      if (s_ff.cs_s)
      begin
         nxt_s.bcnt = 3'h0;
         nxt_s.first = 1'b1;
      end
      else if (rise)
      begin
         nxt_s.shin = byte_in;
         nxt_s.bcnt = s_ff.bcnt + 3'h1;
         if (s_ff.bcnt == MDS_BIT_LAST && s_ff.first)
         begin
            nxt_s.first = 1'b0;
            nxt_s.wr = byte_in[7];
            nxt_s.addr = byte_in[6:0];
            ra = byte_in[6:0];
            rd = ~byte_in[7];
         end
         else if (s_ff.bcnt == MDS_BIT_LAST)
         begin
            if (s_ff.wr)
            begin
               unique case (s_ff.addr)
                  MDS_A_IE1: nxt_s.ie1 = byte_in;
                  MDS_A_IE2: nxt_s.ie2 = byte_in;
                  MDS_A_OPM: nxt_s.opm = byte_in;
                  MDS_A_OP2: nxt_s.op2 = byte_in;
                  MDS_A_PHC: nxt_s.phc = byte_in;
                  MDS_A_MOD: nxt_s.mc = byte_in;
                  MDS_A_FIFO:
                     if (s_ff.st != MDS_RX)
                        f_wv = 1'b1;
                  default: ;
               endcase
            end
            // Burst stays on the FIFO, walks other addresses
            if (s_ff.addr != MDS_A_FIFO)
               nxt_s.addr = s_ff.addr + 7'h1;
            ra = nxt_s.addr;
            rd = ~s_ff.wr;
         end
      end
      else if (fall && s_ff.bcnt != 3'h0)
         nxt_s.shout = {s_ff.shout[6:0], 1'b0};
      if (rd)
      begin
         nxt_s.shout = mds_rd(s_ff, ra, f_rv, f_rd);
         if (ra == MDS_A_FIFO && s_ff.st != MDS_TX)
            f_rr = 1'b1;
      end

      // Pin routing; the serial pins belong to SPI while selected
      if (!s_ff.cs_s)
         nxt_s.sdo = '{out: nxt_s.shout[7], oe_n: 1'b0};
      else if (act_on && s_ff.act.clk == MDS_CLK_SDO)
         nxt_s.sdo = '{out: s_ff.dclk, oe_n: 1'b0};
      else
         nxt_s.sdo = '{out: 1'b0, oe_n: 1'b1};
      if (s_ff.cs_s && s_ff.st == MDS_RX && s_ff.act.src == MDS_SRC_SDI)
         nxt_s.sdi = '{out: rx_demod_bit, oe_n: 1'b0};
      else
         nxt_s.sdi = '{out: 1'b0, oe_n: 1'b1};
      nxt_s.gclk = act_on && (s_ff.act.clk == MDS_CLK_GPIO) && s_ff.dclk;
      if (act_on && s_ff.act.clk == MDS_CLK_IRQ && s_ff.ie1 == 8'h00
         && s_ff.ie2 == 8'h00)
         nxt_s.irqn = s_ff.dclk;
      else
         nxt_s.irqn = ~irq_request;

      // Gaussian shaping needs a known rate, so async falls back
      if (s_ff.act.mods == MDS_GAUSSIAN_FSK && async_m)
         nxt_s.mo = MDS_FSK;
      else
         nxt_s.mo = s_ff.act.mods;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         s_ff <= '0;
         s_ff.cs_m <= 1'b1;
         s_ff.cs_s <= 1'b1;
         s_ff.first <= 1'b1;
         s_ff.mc <= MDS_MOD_RST;
         s_ff.act <= MDS_MOD_RST;
         s_ff.opm <= MDS_OPM_RST;
         s_ff.op2 <= MDS_REG_RST;
         s_ff.lfsr <= MDS_PN9_SEED;
         s_ff.sdo.oe_n <= 1'b1;
         s_ff.sdi.oe_n <= 1'b1;
         s_ff.irqn <= 1'b1;
      end
      else
         s_ff <= nxt_s;
   end

   // Outputs straight from the state register
   assign sdi_pin = s_ff.sdi;
   assign sdo_pin = s_ff.sdo;
   assign gpio_clk_out = s_ff.gclk;
   assign rx_bit_output = s_ff.rxbit;
   assign interrupt_out_n = s_ff.irqn;
   assign tx_mod_bit = s_ff.txbit;
   assign mod_type_out = s_ff.mo;
   assign op_state = s_ff.st;
   assign ph_wrap = s_ff.wrap;
   assign pkt_sent = s_ff.sent;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_mod_follow: assert property (!(s_ff.act.mods == MDS_GAUSSIAN_FSK
      && ~s_ff.act.src[1]) |=> mod_type_out == $past(s_ff.act.mods))
      else $error("modulation output does not follow latched type");
   a_gaussian_fsk_async: assert property (~s_ff.act.src[1]
      && s_ff.act.clk == MDS_CLK_NONE |=> mod_type_out != MDS_GAUSSIAN_FSK)
      else $error("gaussian keying used without data clock");
   a_inv_direct: assert property (s_ff.st == MDS_TX
      && s_ff.act.src == MDS_SRC_GPIO && s_ff.act.clk == MDS_CLK_NONE
      |=> tx_mod_bit == ($past(s_ff.gdi_s) ^ $past(s_ff.act.inv)))
      else $error("direct transmit bit not pin xor invert");
   a_sent_txoff: assert property (pkt_sent |-> $past(s_ff.st) == MDS_TX
      ##1 s_ff.st != MDS_TX || s_ff.opm[MDS_B_TXON])
      else $error("transmit state kept after packet sent");
   a_rx_exit: assert property (s_ff.st == MDS_RX && pkt_valid
      && s_ff.act.src == MDS_SRC_FIFO && !s_ff.op2[MDS_B_MPK]
      && s_ff.cs_s |=> !s_ff.opm[MDS_B_RXON])
      else $error("receive not left on packet valid");
   a_mpk_stay: assert property (s_ff.st == MDS_RX && pkt_valid
      && s_ff.op2[MDS_B_MPK] && s_ff.cs_s |=> s_ff.opm[MDS_B_RXON])
      else $error("multi-packet receive was left");
   a_sdo_spi: assert property (!s_ff.cs_s |=> !sdo_pin.oe_n
      && sdo_pin.out == s_ff.shout[7])
      else $error("serial data out not driven by SPI while selected");
   a_irq_clk: assert property (s_ff.st == MDS_TX
      && s_ff.act.clk == MDS_CLK_IRQ && s_ff.ie1 == 8'h00
      && s_ff.ie2 == 8'h00 |=> interrupt_out_n == $past(s_ff.dclk))
      else $error("interrupt pin does not carry data clock");
   a_cfg_hold: assert property (s_ff.st == MDS_TX ##1 s_ff.st == MDS_TX
      |-> $stable(s_ff.act))
      else $error("configuration changed during transfer");
endmodule // mds_modsrc

// >>> tb/mds_host_model.sv
/*
 Far-side data supplier for direct synchronous transmit.
 Assumes the data clock arrives as a plain level beside sys_clk.
*/
`timescale 1ns/1ns

module mds_host_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic data_clk,
   input wire logic en,
   input wire logic [15:0] pattern,
   output logic data_out
);
   logic clk_q_ff;
   logic [4:0] n_ff;

   // One new bit after each of the first 16 falling clock edges, never ahead of the request
   always @(posedge sys_clk)
   begin
      clk_q_ff <= data_clk;
      if (rst)
      begin
         n_ff <= 5'h00;
         data_out <= 1'b0;
      end
      else if (!en)
      begin
         n_ff <= 5'h00;
         data_out <= ~data_out; // Idle pin never shows a stale bit
      end
      else if (clk_q_ff && !data_clk && n_ff < 5'h10)
      begin
         data_out <= pattern[4'hf - n_ff[3:0]];
         n_ff <= n_ff + 5'h01;
      end
   end
endmodule // mds_host_model

// >>> tb/test_mds_modsrc.sv
/*
 Self-checking bench of the modulation data source block.
 Assumes the SPI port and the host data model are the only far side.
*/
`timescale 1ns/1ns

module test_mds_modsrc;
   import mds_pkg::*;
   logic sys_clk, rst, chip_select_n, spi_clk, sdi_in, gpio_data_in;
   logic half_bit_tick, rx_demod_bit, rx_sync_seen, pkt_valid, irq_request;
   mds_pin_s sdi_pin, sdo_pin;
   logic gpio_clk_out, rx_bit_output, interrupt_out_n, tx_mod_bit;
   logic ph_wrap, pkt_sent, src_en, clk_q;
   mds_mod_e mod_type_out;
   mds_state_e op_state;
   logic [3:0] tick_cnt;
   logic [7:0] q;
   logic [15:0] pattern = 16'hb2d4;
   logic [7:0] tx_bytes [5] = '{8'ha5, 8'h3c, 8'h81, 8'h7e, 8'hff};
   int failures = 0;
   int n_checks = 0;
   int sent_n = 0;

   mds_modsrc dut (.sys_clk(sys_clk), .rst(rst),
      .chip_select_n(chip_select_n), .spi_clk(spi_clk), .sdi_in(sdi_in),
      .gpio_data_in(gpio_data_in), .half_bit_tick(half_bit_tick),
      .rx_demod_bit(rx_demod_bit), .rx_sync_seen(rx_sync_seen),
      .pkt_valid(pkt_valid), .irq_request(irq_request),
      .sdi_pin(sdi_pin), .sdo_pin(sdo_pin), .gpio_clk_out(gpio_clk_out),
      .rx_bit_output(rx_bit_output), .interrupt_out_n(interrupt_out_n),
      .tx_mod_bit(tx_mod_bit), .mod_type_out(mod_type_out),
      .op_state(op_state), .ph_wrap(ph_wrap), .pkt_sent(pkt_sent));

   mds_host_model host (.sys_clk(sys_clk), .rst(rst),
      .data_clk(gpio_clk_out), .en(src_en), .pattern(pattern),
      .data_out(gpio_data_in));

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Rate generator stand-in: half-bit tick every 10 cycles
   always @(posedge sys_clk)
   begin
      tick_cnt <= (tick_cnt == 4'h9) ? 4'h0 : tick_cnt + 4'h1;
      half_bit_tick <= (tick_cnt == 4'h9);
      clk_q <= gpio_clk_out;
      if (pkt_sent === 1'b1)
         sent_n <= sent_n + 1;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   task end_of_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // SPI bit: 80 ns low, 80 ns high, read bit taken at the rising edge
   task spi_bits(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         @(posedge sys_clk);
         spi_clk <= 1'b0;
         sdi_in <= tx[i];
         repeat (8) @(posedge sys_clk);
         rx[i] = sdo_pin.out;
         spi_clk <= 1'b1;
         repeat (7) @(posedge sys_clk);
      end
   endtask

   task spi_open();
      @(posedge sys_clk);
      chip_select_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask

   task spi_close();
      @(posedge sys_clk);
      chip_select_n <= 1'b1;
      spi_clk <= 1'b0;
      sdi_in <= ~sdi_in;
      repeat (8) @(posedge sys_clk);
   endtask

   task spi_wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] z;
      spi_open();
      spi_bits(a | 8'h80, z);
      spi_bits(d, z);
      spi_close();
   endtask

   task spi_rd(input logic [7:0] a, output logic [7:0] r);
      logic [7:0] z;
      spi_open();
      spi_bits(a & 8'h7f, z);
      spi_bits(8'h00, r);
      spi_close();
   endtask

   // Burst into the FIFO access register; address does not advance
   task fifo_fill(input int n);
      logic [7:0] z;
      spi_open();
      spi_bits(8'hff, z);
      for (int i = 0; i < n; i++)
         spi_bits(tx_bytes[i], z);
      spi_close();
   endtask

   task wait_fall();
      int i;
      i = 0;
      do
      begin
         @(posedge sys_clk);
         i++;
      end
      while (!(clk_q === 1'b1 && gpio_clk_out === 1'b0) && i < 100);
      if (i >= 100)
         chk(0, 1, "data clock missing");
   endtask

   task t_regs();
      chk(sdo_pin.oe_n, 1'b1, "sdo released");
      chk(op_state, MDS_STANDBY, "reset state");
      spi_rd(8'h71, q);
      chk(q, 8'h00, "mod reg reset");
      spi_wr(8'h71, 8'h58);
      spi_rd(8'h71, q);
      chk(q, 8'h58, "mod reg rw");
      spi_rd(8'h10, q);
      chk(q, 8'h00, "unmapped read");
      @(posedge sys_clk);
      irq_request <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk(interrupt_out_n, 1'b0, "irq pin");
      irq_request <= 1'b0;
   endtask

   task t_fifo_tx(input logic inv, input logic pll, input logic ph);
      logic [31:0] got;
      int s0;
      spi_wr(8'h30, {4'h0, ph, 3'h0});
      spi_wr(8'h71, {4'h6, inv, 3'h2});
      fifo_fill(5); // Fifth byte meets a full buffer
      s0 = sent_n;
      spi_wr(8'h07, {4'h0, 1'b1, 1'b0, pll, 1'b0});
      chk(op_state, MDS_TX, "tx entry");
      chk(ph_wrap, ph, "wrap flag");
      chk(mod_type_out, MDS_FSK, "mod type");
      for (int k = 31; k >= 0; k--)
      begin
         wait_fall();
         got[k] = tx_mod_bit;
      end
      if (!ph)
         chk(got, {tx_bytes[0], tx_bytes[1], tx_bytes[2], tx_bytes[3]}
            ^ {32{inv}}, "fifo bits");
      for (int i = 0; i < 3000 && sent_n == s0; i++)
         @(posedge sys_clk);
      repeat (3) @(posedge sys_clk);
      chk(sent_n - s0, 1, "pkt sent");
      chk(op_state, pll ? MDS_TUNE : MDS_STANDBY, "idle");
      spi_rd(8'h07, q);
      chk(q, {6'h00, pll, 1'b0}, "txon cleared");
   endtask

   task t_direct_sync();
      time tp;
      @(posedge sys_clk);
      src_en <= 1'b1;
      spi_wr(8'h71, 8'h43);
      spi_wr(8'h07, 8'h08);
      chk(mod_type_out, MDS_GAUSSIAN_FSK, "sync gaussian_fsk");
      wait_fall();
      tp = $time;
      for (int j = 2; j <= 16; j++)
      begin
         wait_fall();
         chk(tx_mod_bit, pattern[17-j], "direct bit");
         chk(int'(($time - tp) / 10), 20, "clock period");
         tp = $time;
      end
      spi_wr(8'h71, 8'h42);
      chk(mod_type_out, MDS_GAUSSIAN_FSK, "held config");
      spi_wr(8'h07, 8'h00);
      spi_wr(8'h07, 8'h08);
      chk(mod_type_out, MDS_FSK, "config at entry");
      spi_wr(8'h07, 8'h00);
   endtask

   task t_async();
      spi_wr(8'h71, 8'h0b);
      spi_wr(8'h07, 8'h08);
      repeat (20) @(posedge sys_clk);
      chk(mod_type_out, MDS_FSK, "async no gaussian_fsk");
      chk(gpio_clk_out, 1'b0, "no clock");
      chk(tx_mod_bit, !gpio_data_in, "async pass");
      spi_wr(8'h07, 8'h00);
   endtask

   task t_irq_clk(input logic [7:0] ie);
      int lows;
      lows = 0;
      spi_wr(8'h05, ie);
      spi_wr(8'h71, 8'hc2);
      spi_wr(8'h07, 8'h08);
      for (int i = 0; i < 40; i++)
      begin
         @(posedge sys_clk);
         lows += (interrupt_out_n === 1'b0);
      end
      chk(lows, (ie == 8'h00) ? 20 : 0, "irq pin clock");
      spi_wr(8'h07, 8'h00);
      spi_wr(8'h05, 8'h00);
   endtask

   // Internal sequence with a plain carrier type, clock on the gpio
   task t_pn9();
      logic [8:0] e;
      e = MDS_PN9_SEED;
      spi_wr(8'h71, 8'h70);
      spi_wr(8'h07, 8'h08);
      chk(mod_type_out, MDS_CW, "carrier type");
      for (int k = 0; k < 20; k++)
      begin
         wait_fall();
         chk(tx_mod_bit, e[8], "pseudorandom bit");
         e = {e[7:0], e[8] ^ e[4]};
      end
      spi_wr(8'h07, 8'h00);
   endtask

   // Serial pins as data and clock while select is high
   task t_sdi();
      int lows, drv;
      lows = 0;
      drv = 0;
      spi_wr(8'h71, 8'h91);
      spi_wr(8'h07, 8'h04); // direct receive, no sync word
      chk(mod_type_out, MDS_OOK, "on off type");
      for (int i = 0; i < 4; i++)
      begin
         rx_demod_bit <= i[0];
         repeat (3) @(posedge sys_clk);
         chk(sdi_pin, {i[0], 1'b0}, "sdi rx data");
      end
      for (int i = 0; i < 40; i++)
      begin
         @(posedge sys_clk);
         lows += (sdo_pin.out === 1'b0);
         drv += (sdo_pin.oe_n === 1'b0);
      end
      chk(lows, 20, "sdo data clock");
      chk(drv, 40, "sdo driven");
      spi_wr(8'h07, 8'h08);
      repeat (50) @(posedge sys_clk);
      chk(tx_mod_bit, sdi_in, "sdi tx data");
      spi_wr(8'h07, 8'h00);
   endtask

   task t_rx(input logic mpk);
      logic [7:0] b;
      b = 8'hc3;
      spi_wr(8'h08, {3'h0, mpk, 4'h0});
      spi_wr(8'h71, 8'h62);
      spi_wr(8'h07, 8'h04);
      chk(op_state, MDS_RX, "rx entry");
      wait_fall();
      rx_demod_bit <= 1'b1; // Preamble bits, never stored
      repeat (2) @(posedge sys_clk);
      chk(rx_bit_output, 1'b1, "live rx bit");
      wait_fall();
      rx_sync_seen <= 1'b1;
      rx_demod_bit <= b[7];
      @(posedge sys_clk);
      rx_sync_seen <= 1'b0;
      for (int i = 6; i >= 0; i--)
      begin
         wait_fall();
         rx_demod_bit <= b[i];
      end
      wait_fall();
      pkt_valid <= 1'b1;
      @(posedge sys_clk);
      pkt_valid <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk(op_state, mpk ? MDS_RX : MDS_STANDBY, "rx exit");
      spi_rd(8'h7f, q);
      chk(q, 8'hc3, "rx byte");
      spi_rd(8'h7f, q);
      chk(q, 8'h00, "no sync bytes");
      spi_wr(8'h07, 8'h00);
      spi_wr(8'h08, 8'h00);
   endtask

   initial
   begin
      repeat (60000) @(posedge sys_clk);
      failures++;
      end_of_test();
   end

   initial
   begin
      rst = 1'b1;
      chip_select_n = 1'b1;
      spi_clk = 1'b0;
      sdi_in = 1'b0;
      rx_demod_bit = 1'b0;
      rx_sync_seen = 1'b0;
      pkt_valid = 1'b0;
      irq_request = 1'b0;
      src_en = 1'b0;
      tick_cnt = 4'h0;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      t_regs();
      t_fifo_tx(1'b0, 1'b1, 1'b0);
      t_fifo_tx(1'b1, 1'b0, 1'b0);
      t_fifo_tx(1'b0, 1'b0, 1'b1);
      t_direct_sync();
      t_async();
      t_pn9();
      t_sdi();
      t_irq_clk(8'h01);
      t_irq_clk(8'h00);
      t_rx(1'b0);
      t_rx(1'b1);
      end_of_test();
   end
endmodule // test_mds_modsrc
